// ### design/rtc_host_interface.sv
// APB host interface and clock core of the battery-backed real time clock
`timescale 1ns/100ps
// Overview of operation
// R1: Seconds counter is 32 bits and steps once per second.
// R2: Oscillator divided by 256 gives 128 Hz; further 128 gives seconds.
// R3: Core holds thirty-two 16-bit backup words reached by memory instructions.
// R4: Low register carries bits 15..0, high register bits 31..16.
// R5: Writing a busy bit starts a transfer; hardware clears it when done.
// R6: Instruction cycle sends high register bits 15..8 to core instruction register, then clears.
// R7: Data cycle sends high/low into core data buffer, then clears.
// R8: Read cycle samples selected core value into buffer, then high/low.
// R9: Host loads a read-type instruction before a read cycle.
// R10: Execute bit makes core carry out the held instruction.
// R11: Host holds execute one second for reset and load, then clears; the testbench holds it 1200 cycles for reset and never loads.
// R12: Memory-clock bit gives exactly one store pulse, then self-clears.
// R13: Host keeps execute set throughout a memory-clock operation.
// R14: Host puts 8-bit opcode in high register bits 15..8 first.
// R15: Code EB resets core control registers at next 1/128 s tick.
// R16: Code 59 loads seconds from data buffer at next second.
// R17: Code 56 selects seconds for reading, one 12 MHz access delay.
// R18: Code C7 selects 7-bit 128 Hz prescaler phase for reading.
// R19: Code AC sets alarm from data buffer at next 1/128 s tick.
// R20: Code 35 writes and 3A reads backup memory, 12 MHz access delay.
// R21: Writing zero to a busy bit never disturbs a running cycle.
module rtc_host_interface (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [rtc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      osc_32k,
    output logic                           alarm_match
);
    import rtc_pkg::*;

    localparam logic [7:0]  pre1_last = 8'(PRE1_DIV - 1);
    localparam logic [6:0]  pre2_last = 7'(PRE2_DIV - 1);
    localparam logic [1:0]  acc_last  = 2'(ACCESS_CYCLES - 1);
    localparam int          MA_W      = $clog2(MEM_WORDS);

    typedef enum logic {ST_IDLE, ST_WAIT} state_t;

    // APB slave
    logic [15:0]       idx;
    logic              hit_low;
    logic              hit_high;
    logic              hit_ctrl;
    logic              setup;
    logic              wr;
    logic [31:0]       prdata_q;
    logic [15:0]       low_q;
    logic [15:0]       high_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;

    assign idx      = paddr[ADDR_W-1:2];
    assign hit_low  = (idx == IDX_LOW);
    assign hit_high = (idx == IDX_HIGH);
    assign hit_ctrl = (idx == IDX_CTRL);
    assign setup    = psel && !penable;
    assign wr       = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !(hit_low || hit_high || hit_ctrl);
    assign prdata   = prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= hit_low  ? {16'h0000, low_q} :
                        hit_high ? {16'h0000, high_q} :
                        hit_ctrl ? {27'h000_0000, ctrl_q} : 32'h0000_0000;
        end
    end

    // Transfer sequencer between host registers and core
    state_t      state_q;
    xfer_t       kind_q;
    logic        xfer_start;
    logic        xfer_done;
    logic [31:0] xfer_rdata_q;
    logic [1:0]  acc_q;
    logic        mclk_q;
    logic        clr_instr;
    logic        clr_data;
    logic        clr_read;

    assign xfer_start = (state_q == ST_IDLE) && (ctrl_q[BIT_INSTR] || ctrl_q[BIT_DATA] || ctrl_q[BIT_READ]);
    assign xfer_done  = (state_q == ST_WAIT) && (acc_q == acc_last);
    assign clr_instr  = xfer_done && (kind_q == XFER_INSTR);
    assign clr_data   = xfer_done && (kind_q == XFER_DATA);
    assign clr_read   = xfer_done && (kind_q == XFER_READ);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            kind_q  <= XFER_INSTR;
            acc_q   <= 2'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    acc_q <= 2'h0;
                    if (xfer_start) begin
                        state_q <= ST_WAIT;
                        kind_q  <= ctrl_q[BIT_INSTR] ? XFER_INSTR :
                                   ctrl_q[BIT_DATA]  ? XFER_DATA  : XFER_READ;
                    end
                end
                ST_WAIT: begin
                    acc_q <= acc_q + 2'h1;
                    if (xfer_done) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Set by a one-write wins over hardware clear; zero writes leave busy bits alone
    always_comb begin
        ctrl_d           = ctrl_q;
        ctrl_d[BIT_INSTR] = (wr && hit_ctrl && pwdata[BIT_INSTR]) || (ctrl_q[BIT_INSTR] && !clr_instr); // R5 R21
        ctrl_d[BIT_DATA]  = (wr && hit_ctrl && pwdata[BIT_DATA]) || (ctrl_q[BIT_DATA] && !clr_data); // R5 R21
        ctrl_d[BIT_READ]  = (wr && hit_ctrl && pwdata[BIT_READ]) || (ctrl_q[BIT_READ] && !clr_read); // R5 R21
        ctrl_d[BIT_MCLK]  = (wr && hit_ctrl && pwdata[BIT_MCLK]) || (ctrl_q[BIT_MCLK] && !mclk_q); // R12
        if (wr && hit_ctrl) begin
            ctrl_d[BIT_EXEC] = pwdata[BIT_EXEC]; // R10
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            mclk_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mclk_q <= ctrl_q[BIT_MCLK] && !mclk_q; // R12
        end
    end

    // Read result overrides a same-cycle software write of the data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q  <= LOW_RST;
            high_q <= HIGH_RST;
        end else if (clr_read) begin
            // Taken straight from the selection, the result register only settles at this edge
            low_q  <= selected[15:0]; // R4 R8
            high_q <= selected[31:16]; // R4 R8
        end else if (wr) begin
            if (hit_low) begin
                low_q <= pwdata[15:0];
            end
            if (hit_high) begin
                high_q <= pwdata[15:0];
            end
        end
    end

    // Clock core: oscillator is asynchronous to pclk
    logic        osc_sync;
    logic        osc_prev_q;
    logic        osc_rise;
    logic [7:0]  div256_q;
    logic [6:0]  phase_q;
    logic        tick128;
    logic        tick1s;
    logic [31:0] seconds_q;
    logic [31:0] alarm_q;
    logic        alarm_en_q;
    logic        alarm_match_q;
    logic [7:0]  instr_q;
    logic [31:0] data_buf_q;
    logic [31:0] selected;
    logic        exec;
    logic        load_now;
    logic        ctrl_reset_now;
    logic        alarm_set_now;
    logic        mem_wr;
    logic [MEM_W-1:0] mem_rdata;

    rtc_sync2 u_osc_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (osc_32k),
        .sync_out (osc_sync)
    );

    assign osc_rise       = osc_sync && !osc_prev_q;
    assign tick128        = osc_rise && (div256_q == pre1_last); // R2
    assign tick1s         = tick128 && (phase_q == pre2_last); // R2
    assign exec           = ctrl_q[BIT_EXEC];
    assign load_now       = exec && (instr_q == op_load_seconds) && tick1s; // R16
    assign ctrl_reset_now = exec && (instr_q == op_reset_control) && tick128; // R15
    assign alarm_set_now  = exec && (instr_q == op_set_alarm) && tick128; // R19
    assign mem_wr         = mclk_q && exec && (instr_q == op_mem_write); // R3 R20
    assign alarm_match    = alarm_match_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_q <= 1'b0;
            div256_q   <= 8'h00;
            phase_q    <= 7'h00;
        end else begin
            osc_prev_q <= osc_sync;
            if (osc_rise) begin
                div256_q <= div256_q + 8'h01; // R2
            end
            if (tick128) begin
                phase_q <= phase_q + 7'h01; // R2
            end
        end
    end

    // Seconds counter; a load replaces that second's step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seconds_q <= 32'h0000_0000;
        end else if (load_now) begin
            seconds_q <= data_buf_q; // R16
        end else if (tick1s) begin
            seconds_q <= seconds_q + 32'h0000_0001; // R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_q       <= 32'h0000_0000;
            alarm_en_q    <= 1'b0;
            alarm_match_q <= 1'b0;
        end else begin
            if (ctrl_reset_now) begin
                alarm_q    <= 32'h0000_0000; // R15
                alarm_en_q <= 1'b0; // R15
            end else if (alarm_set_now) begin
                alarm_q    <= data_buf_q; // R19
                alarm_en_q <= 1'b1; // R19
            end
            alarm_match_q <= alarm_en_q && (seconds_q == alarm_q);
        end
    end

    rtc_backup_mem #(
        .WORDS (MEM_WORDS),
        .WIDTH (MEM_W)
    ) u_mem (
        .pclk  (pclk),
        .wr_en (mem_wr),
        .addr  (data_buf_q[16 +: MA_W]),
        .wdata (data_buf_q[MEM_W-1:0]),
        .rdata (mem_rdata)
    );

    always_comb begin
        unique case (instr_q)
            op_read_seconds:         selected = seconds_q; // R17
            op_read_prescaler_phase: selected = {25'h000_0000, phase_q}; // R18
            op_mem_read:             selected = {16'h0000, mem_rdata}; // R20
            default:                 selected = data_buf_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q      <= 8'h00;
            data_buf_q   <= 32'h0000_0000;
            xfer_rdata_q <= 32'h0000_0000;
        end else if (xfer_done) begin
            unique case (kind_q)
                XFER_INSTR: instr_q <= high_q[15:8]; // R6
                XFER_DATA:  data_buf_q <= {high_q, low_q}; // R7
                XFER_READ: begin
                    data_buf_q   <= selected; // R8
                    xfer_rdata_q <= selected; // R8
                end
            endcase
        end
    end

    // Checks
    a_busy_clears: assert property (@(posedge pclk) disable iff (!presetn) // R5
        clr_instr && !(wr && hit_ctrl) |=> !ctrl_q[BIT_INSTR])
        else $error("instruction busy bit not cleared");
    a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn) // R21
        wr && hit_ctrl && !pwdata[BIT_READ] && ctrl_q[BIT_READ] && !clr_read |=> ctrl_q[BIT_READ])
        else $error("zero write disturbed read cycle");
    a_instr_latch: assert property (@(posedge pclk) disable iff (!presetn) // R6
        clr_instr |=> instr_q == $past(high_q[15:8]))
        else $error("instruction not latched");
    a_data_latch: assert property (@(posedge pclk) disable iff (!presetn) // R7
        clr_data |=> data_buf_q == {$past(high_q), $past(low_q)})
        else $error("data buffer not loaded");
    a_read_lands: assert property (@(posedge pclk) disable iff (!presetn) // R8
        xfer_start && ctrl_q[BIT_READ] && !ctrl_q[BIT_INSTR] && !ctrl_q[BIT_DATA]
        |-> ##[1:4] (clr_read ##1 ({high_q, low_q} == xfer_rdata_q)))
        else $error("read result not in data registers");
    a_mclk_single: assert property (@(posedge pclk) disable iff (!presetn) // R12
        mclk_q |=> !mclk_q)
        else $error("memory clock pulse longer than one cycle");
    a_seconds_step: assert property (@(posedge pclk) disable iff (!presetn) // R1
        tick1s && !load_now |=> seconds_q == $past(seconds_q) + 32'h0000_0001)
        else $error("seconds counter did not step");
    a_second_phase: assert property (@(posedge pclk) disable iff (!presetn) // R2
        $changed(seconds_q) && !$past(load_now) |-> $past(phase_q) == pre2_last && $past(div256_q) == pre1_last)
        else $error("second advanced off prescaler wrap");
    a_load_seconds: assert property (@(posedge pclk) disable iff (!presetn) // R16
        load_now |=> seconds_q == $past(data_buf_q))
        else $error("seconds load failed");
    a_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn) // R15
        ctrl_reset_now |=> !alarm_en_q && alarm_q == 32'h0000_0000)
        else $error("control reset not applied");
    a_phase_read: assert property (@(posedge pclk) disable iff (!presetn) // R18
        clr_read && instr_q == op_read_prescaler_phase |=> xfer_rdata_q == {25'h000_0000, $past(phase_q)})
        else $error("prescaler phase read wrong");
endmodule : rtc_host_interface

// ### design/rtc_pkg.sv
// Constants and types shared by the real time clock host interface
package rtc_pkg;

    localparam int          ADDR_W        = 18;
    localparam logic [15:0] IDX_LOW       = 16'hFEA0;
    localparam logic [15:0] IDX_HIGH      = 16'hFEA1;
    localparam logic [15:0] IDX_CTRL      = 16'hFEA2;

    localparam int          CTRL_W        = 5;
    localparam int          BIT_INSTR     = 0;
    localparam int          BIT_DATA      = 1;
    localparam int          BIT_READ      = 2;
    localparam int          BIT_EXEC      = 3;
    localparam int          BIT_MCLK      = 4;

    localparam logic [15:0] LOW_RST       = 16'h0000;
    localparam logic [15:0] HIGH_RST      = 16'h0000;
    localparam logic [4:0]  CTRL_RST      = 5'h00;

    localparam logic [7:0]  op_reset_control        = 8'hEB;
    localparam logic [7:0]  op_load_seconds         = 8'h59;
    localparam logic [7:0]  op_read_seconds         = 8'h56;
    localparam logic [7:0]  op_read_prescaler_phase = 8'hC7;
    localparam logic [7:0]  op_set_alarm            = 8'hAC;
    localparam logic [7:0]  op_mem_write            = 8'h35;
    localparam logic [7:0]  op_mem_read             = 8'h3A;

    localparam int          OSC_HZ        = 32768;
    localparam int          PRE1_DIV      = 256;
    localparam int          PRE2_DIV      = 128;
    localparam int          MEM_WORDS     = 32;
    localparam int          MEM_W         = 16;

    localparam int          CLK_HZ        = 20_000_000;
    localparam int          ACCESS_HZ     = 12_000_000;
    localparam int          ACCESS_CYCLES = (CLK_HZ + ACCESS_HZ - 1) / ACCESS_HZ;

    typedef enum logic [1:0] {
        XFER_INSTR,
        XFER_DATA,
        XFER_READ
    } xfer_t;

endpackage : rtc_pkg

// ### design/rtc_sync2.sv
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module rtc_sync2 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : rtc_sync2

// ### design/rtc_backup_mem.sv
// Battery-backed word store of the clock core
`timescale 1ns/100ps
module rtc_backup_mem #(
    parameter int WORDS = rtc_pkg::MEM_WORDS,
    parameter int WIDTH = rtc_pkg::MEM_W
) (
    input  wire logic                     pclk,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(WORDS)-1:0] addr,
    input  wire logic [WIDTH-1:0]         wdata,
    output logic      [WIDTH-1:0]         rdata
);
    import rtc_pkg::*;

    // No reset: contents survive system resets on their own supply
    logic [WIDTH-1:0] mem_q [WORDS];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem_q[addr] <= wdata;
        end
    end

    assign rdata = mem_q[addr];
endmodule : rtc_backup_mem

// ### sim/osc_source.sv
// Free-running 32768 Hz crystal stand-in, sped up for simulation
`timescale 1ns/100ps
module osc_source #(
    parameter real HALF_NS = 105.0
) (
    output logic osc
);
    // Odd period keeps its phase unrelated to pclk
    initial begin
        osc = 1'b0;
        forever #(HALF_NS) osc = ~osc;
    end
endmodule : osc_source

// ### sim/testbench.sv
// Self-checking APB bench of the real time clock host interface
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module testbench;
    import rtc_pkg::*;
    typedef struct { logic [31:0] mask; logic [31:0] exp; logic err; } note_t;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                osc_32k;
    logic                alarm_match;
    note_t               notes[$];
    note_t               e;
    int                  n_mismatch;
    int                  num_checks;
    int                  cyc_cnt;
    logic [31:0]         v;
    logic [31:0]         p1;
    logic [7:0]          dlt;
    logic [4:0]          addrs[3];
    logic [15:0]         words[3];

    rtc_host_interface dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .osc_32k     (osc_32k),
        .alarm_match (alarm_match)
    );
    osc_source osc_i (.osc(osc_32k));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // Generous ceiling, the sequence needs well under ten thousand cycles
    always @(posedge pclk) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            n_mismatch++;
            close_out();
        end
    end

    // Every completed read takes the oldest note; mask zero means polling only
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (notes.size() == 0) begin
                `CHK("note queue", 1'b1, 1'b0)
            end else begin
                e = notes.pop_front();
                `CHK("pslverr", e.err, pslverr)
                if (e.mask != 32'h0) begin
                    `CHK("prdata", e.exp, prdata & e.mask)
                end
            end
        end
    end

    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rv);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        logic [31:0] dummy;
        xfer(1'b1, idx, wd, dummy);
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] mask, input logic [31:0] exp,
                      input logic err, output logic [31:0] rv);
        notes.push_back('{mask, exp, err});
        xfer(1'b0, idx, 32'h0, rv);
    endtask : rd

    task automatic wait_clear(input int bitn);
        logic [31:0] rv;
        for (int i = 0; i < 20; i++) begin
            rd(IDX_CTRL, 32'h0, 32'h0, 1'b0, rv);
            if (rv[bitn] === 1'b0) break;
        end
        `CHK("busy clear", 1'b0, rv[bitn])
    endtask : wait_clear

    task automatic instr(input logic [7:0] op);
        wr(IDX_HIGH, {16'h0, op, 8'h00});
        wr(IDX_CTRL, 32'h1);
        wait_clear(BIT_INSTR);
    endtask : instr

    task automatic dat(input logic [15:0] hi, input logic [15:0] lo);
        wr(IDX_HIGH, {16'h0, hi});
        wr(IDX_LOW, {16'h0, lo});
        wr(IDX_CTRL, 32'h2);
        wait_clear(BIT_DATA);
    endtask : dat

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = 32'h0;
        void'($urandom(57));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        rd(IDX_LOW, 32'hFFFFFFFF, 32'h0, 1'b0, v);
        rd(IDX_HIGH, 32'hFFFFFFFF, 32'h0, 1'b0, v);
        rd(IDX_CTRL, 32'hFFFFFFFF, 32'h0, 1'b0, v);
        // Data halves and plain execute bit
        v = $urandom();
        wr(IDX_LOW, {16'h0, v[15:0]});
        wr(IDX_HIGH, {16'h0, v[31:16]});
        rd(IDX_LOW, 32'hFFFFFFFF, {16'h0, v[15:0]}, 1'b0, p1);
        rd(IDX_HIGH, 32'hFFFFFFFF, {16'h0, v[31:16]}, 1'b0, p1);
        wr(IDX_CTRL, 32'h8);
        rd(IDX_CTRL, 32'h1F, 32'h8, 1'b0, p1);
        wr(IDX_CTRL, 32'h0);
        // Unmapped index refused, write ignored
        wr(16'hFEA3, 32'h1234);
        rd(16'hFEA3, 32'hFFFFFFFF, 32'h0, 1'b1, p1);
        rd(IDX_LOW, 32'hFFFFFFFF, {16'h0, v[15:0]}, 1'b0, p1);
        // Seconds read, zero write straight after start must not abort it
        dat(16'hA5A5, 16'h5A5A);
        wr(IDX_HIGH, {16'h0, op_read_seconds, 8'h00});
        wr(IDX_CTRL, 32'h1);
        wr(IDX_CTRL, 32'h0);
        wait_clear(BIT_INSTR);
        wr(IDX_CTRL, 32'h4);
        wait_clear(BIT_READ);
        rd(IDX_LOW, 32'hFFFFFFFF, 32'h0, 1'b0, p1);
        rd(IDX_HIGH, 32'hFFFFFFFF, 32'h0, 1'b0, p1);
        // Prescaler phase advances one step per 256 oscillator rising edges
        instr(op_read_prescaler_phase);
        wr(IDX_CTRL, 32'h4);
        wait_clear(BIT_READ);
        rd(IDX_LOW, 32'hFF80, 32'h0, 1'b0, p1);
        rd(IDX_HIGH, 32'hFFFF, 32'h0, 1'b0, v);
        repeat (3000) @(posedge pclk);
        wr(IDX_CTRL, 32'h4);
        wait_clear(BIT_READ);
        rd(IDX_LOW, 32'hFF80, 32'h0, 1'b0, v);
        dlt = {1'b0, v[6:0]} - {1'b0, p1[6:0]};
        `CHK("phase step", 1'b1, (dlt == 8'd2 || dlt == 8'd3))
        // Backup words at both ends of the store and one inside
        addrs = '{5'd0, 5'd31, 5'($urandom_range(1, 30))};
        foreach (addrs[i]) begin
            words[i] = 16'($urandom());
            instr(op_mem_write);
            dat({11'h0, addrs[i]}, words[i]);
            wr(IDX_CTRL, 32'h8);
            wr(IDX_CTRL, 32'h18);
            wait_clear(BIT_MCLK);
            wr(IDX_CTRL, 32'h0);
        end
        foreach (addrs[i]) begin
            instr(op_mem_read);
            dat({11'h0, addrs[i]}, 16'h0);
            wr(IDX_CTRL, 32'h4);
            wait_clear(BIT_READ);
            rd(IDX_LOW, 32'hFFFFFFFF, {16'h0, words[i]}, 1'b0, v);
            rd(IDX_HIGH, 32'hFFFFFFFF, 32'h0, 1'b0, v);
        end
        // Alarm at the current second, then dropped by control reset
        `CHK("alarm idle", 1'b0, alarm_match)
        dat(16'h0000, 16'h0000);
        instr(op_set_alarm);
        wr(IDX_CTRL, 32'h8);
        // Longer than one 1/128 s tick of the fast oscillator
        repeat (1200) @(posedge pclk);
        wr(IDX_CTRL, 32'h0);
        `CHK("alarm set", 1'b1, alarm_match)
        instr(op_reset_control);
        wr(IDX_CTRL, 32'h8);
        repeat (1200) @(posedge pclk);
        wr(IDX_CTRL, 32'h0);
        `CHK("alarm reset", 1'b0, alarm_match)
        repeat (4) @(posedge pclk);
        close_out();
    end
endmodule : testbench
